// ---- hw/acrc_dev.sv ----
// converter end: start decode, shutdown, conversion timing and data bus
`timescale 1ns/10ps
`default_nettype none
module acrc_dev
(
  input  wire logic                 clock_i,
  input  wire logic                 resetn_i,
  input  wire logic                 enable_i,
  acrc_if.dev                       bus,
  input  wire acrc_pkg::acrc_word_t sample_i,
  input  wire logic                 bipolar_i,
  output logic                      shutdown_o,
  output logic                      done_o
);
  import acrc_pkg::*;

  acrc_dev_state_t        state_q;
  logic [CNT_W-1:0]       cnt_q;
  logic                   start_dly_q;
  logic                   pend_q;
  acrc_word_t             result_q;
  logic                   busy_n_q;
  logic                   oe_q;
  logic                   start_fall;
  logic                   conv_end;

  // edge detect keeps a held-low start from retriggering after a conversion
  assign start_fall = start_dly_q & ~bus.conversion_start_n & ~bus.select_n;
  assign conv_end   = (state_q == ST_CONV) && (cnt_q == CNT_W'(CONV_CYC - 1));

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      start_dly_q <= 1'b1;
    else if (enable_i)
      start_dly_q <= bus.conversion_start_n;
  end

  // a start edge before the last acquisition cycle is held until power-down, so every later acquisition ends in another conversion
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      pend_q <= 1'b0;
    else if (enable_i)
    begin
      if (!bus.power_down_n || state_q == ST_IDLE)
        pend_q <= 1'b0;
      else if (start_fall && state_q == ST_ACQ)
        pend_q <= 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_q <= ST_IDLE;
      cnt_q   <= '0;
    end
    else if (enable_i)
    begin
      case (state_q)
        ST_IDLE:
        begin
          cnt_q <= '0;
          if (!bus.power_down_n)
            state_q <= ST_OFF;
          else if (start_fall)
            state_q <= ST_CONV;
        end
        ST_CONV:
        begin
          // further starts are not looked at until the count runs out
          cnt_q <= cnt_q + 1'b1;
          if (conv_end)
          begin
            state_q <= ST_ACQ;
            cnt_q   <= '0;
          end
        end
        ST_ACQ:
        begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == CNT_W'(ACQ_CYC - 1))
          begin
            cnt_q   <= '0;
            state_q <= (pend_q && bus.power_down_n) ? ST_CONV : ST_IDLE;
          end
        end
        ST_OFF:
        begin
          // starts ignored while off and through the wake-up time
          if (!bus.power_down_n)
            cnt_q <= '0;
          else if (cnt_q == CNT_W'(WAKE_CYC - 1))
            state_q <= ST_IDLE;
          else
            cnt_q <= cnt_q + 1'b1;
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // result and busy change on the same edge so the rising busy edge samples new data
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      result_q <= RESULT_RST;
    else if (enable_i && conv_end)
      result_q <= bipolar_i ? (sample_i ^ BIPOLAR_FLIP) : sample_i;
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      busy_n_q <= 1'b1;
    else if (enable_i)
    begin
      if (conv_end)
        busy_n_q <= 1'b1;
      else if ((state_q == ST_IDLE && bus.power_down_n && start_fall) ||
               (state_q == ST_ACQ && cnt_q == CNT_W'(ACQ_CYC - 1) && pend_q && bus.power_down_n))
        busy_n_q <= 1'b0;
    end
  end

  // one cycle of latency on the enable keeps the output a flop
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      oe_q <= 1'b0;
    else if (enable_i)
      oe_q <= ~bus.select_n & ~bus.read_n;
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      shutdown_o <= 1'b0;
      done_o     <= 1'b0;
    end
    else if (enable_i)
    begin
      shutdown_o <= ~bus.power_down_n;
      done_o     <= conv_end;
    end
  end

  assign bus.busy_n   = busy_n_q;
  assign bus.data_out = result_q;
  assign bus.data_oe  = oe_q;
endmodule : acrc_dev
`default_nettype wire

// ---- hw/acrc_host.sv ----
// processor end: requests a conversion and reads the result back
`timescale 1ns/10ps
`default_nettype none
module acrc_host
(
  input  wire logic                 clock_i,
  input  wire logic                 resetn_i,
  input  wire logic                 enable_i,
  acrc_if.host                      bus,
  input  wire logic                 req_i,
  input  wire logic                 sleep_i,
  output logic                      ready_o,
  output logic                      valid_o,
  output acrc_pkg::acrc_word_t      data_o
);
  import acrc_pkg::*;

  acrc_host_state_t  state_q;
  logic              rd_n_q;
  logic              pd_n_q;
  logic [CNT_W-1:0]  wake_q;

  // stall-mode master: read and start share one line
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_q <= HS_IDLE;
      rd_n_q  <= 1'b1;
      valid_o <= 1'b0;
      data_o  <= RESULT_RST;
    end
    else if (enable_i)
    begin
      valid_o <= 1'b0;
      case (state_q)
        HS_IDLE:
          if (req_i && ready_o)
          begin
            rd_n_q  <= 1'b0;
            state_q <= HS_WAIT;
          end
        HS_WAIT:
          if (!bus.busy_n)
            state_q <= HS_READ;
        HS_READ:
          if (bus.busy_n)
          begin
            data_o  <= bus.data_out;
            valid_o <= 1'b1;
            rd_n_q  <= 1'b1;
            state_q <= HS_DONE;
          end
        HS_DONE:
          state_q <= HS_IDLE;
        default:
          state_q <= HS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pd_n_q <= 1'b1;
      wake_q <= '0;
    end
    else if (enable_i)
    begin
      pd_n_q <= ~(sleep_i && state_q == HS_IDLE);
      if (!pd_n_q)
        wake_q <= CNT_W'(WAKE_CYC + 1);
      else if (wake_q != '0)
        wake_q <= wake_q - 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      ready_o <= 1'b0;
    else if (enable_i)
      // ready also drops on the edge that takes a request, so it is already low when the state leaves HS_IDLE
      ready_o <= pd_n_q && !sleep_i && wake_q == '0 && state_q == HS_IDLE && !(req_i && ready_o);
  end

  assign bus.select_n           = 1'b0;
  assign bus.read_n             = rd_n_q;
  assign bus.conversion_start_n = rd_n_q;
  assign bus.power_down_n       = pd_n_q;
endmodule : acrc_host
`default_nettype wire

// ---- pkg/acrc_if.sv ----
// pin-level link between the converter control and its processor
`timescale 1ns/10ps
`default_nettype none
interface acrc_if;
  logic                    select_n;
  logic                    read_n;
  logic                    conversion_start_n;
  logic                    power_down_n;
  logic                    busy_n;
  acrc_pkg::acrc_word_t    data_out;
  logic                    data_oe;

  modport dev
  (
    input  select_n,
    input  read_n,
    input  conversion_start_n,
    input  power_down_n,
    output busy_n,
    output data_out,
    output data_oe
  );

  modport host
  (
    output select_n,
    output read_n,
    output conversion_start_n,
    output power_down_n,
    input  busy_n,
    input  data_out,
    input  data_oe
  );
endinterface : acrc_if
`default_nettype wire

// ---- pkg/acrc_pkg.sv ----
// constants and types shared by both ends of the converter read/start link
// Function
// - start needs select low; ignored when deselected
// - running conversion cannot restart or abort
// - busy low for whole conversion, else high
// - 1.4us conversion, 160ns acquisition, 600ksps
// - power-down low holds device in shutdown
// - no conversion starts during shutdown
// - 350ns wake-up before next start
// - start on falling edge; narrow pulses accepted; code samples start on the clock, so a pulse must span a rising edge
// - select and read low: data driven continuously
// - otherwise data tri-stated until read strobe
// - tied read/start: convert, show previous result
// - new result on bus before busy rises; code loads result_q on the same edge busy rises
// - stall mode: wait busy, then raise read
// - pipelined: each read returns old, starts new
// - unipolar straight binary, bipolar two's complement
package acrc_pkg;
  localparam int unsigned CLK_MHZ         = 40;
  localparam int unsigned DATA_W          = 12;
  localparam int unsigned CONV_TIME_NS    = 1400;
  localparam int unsigned ACQ_TIME_NS     = 160;
  localparam int unsigned WAKE_TIME_NS    = 350;
  localparam int unsigned CONV_CYC        = (CONV_TIME_NS * CLK_MHZ) / 1000;
  localparam int unsigned ACQ_CYC         = (ACQ_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned WAKE_CYC        = (WAKE_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CNT_W           = 7;
  localparam logic [11:0] RESULT_RST      = 12'h000;
  localparam logic [11:0] BIPOLAR_FLIP    = 12'h800;

  typedef logic [DATA_W-1:0] acrc_word_t;

  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01,
    ST_ACQ  = 2'b11,
    ST_OFF  = 2'b10
  } acrc_dev_state_t;

  typedef enum logic [1:0]
  {
    HS_IDLE = 2'b00,
    HS_WAIT = 2'b01,
    HS_READ = 2'b11,
    HS_DONE = 2'b10
  } acrc_host_state_t;
endpackage : acrc_pkg

// ---- test/acrc_assertions.sv ----
// link checks between converter and processor ends
`timescale 1ns/10ps
`default_nettype none
module acrc_assertions
  import acrc_pkg::*;
(
  input wire logic       clock_i,
  input wire logic       resetn_i,
  input wire logic       select_n,
  input wire logic       read_n,
  input wire logic       conversion_start_n,
  input wire logic       power_down_n,
  input wire logic       busy_n,
  input wire acrc_word_t data_out,
  input wire logic       data_oe
);
  logic [6:0] low_q;
  always_ff @(posedge clock_i or negedge resetn_i)
    if (!resetn_i) low_q <= 7'h00;
    else low_q <= busy_n ? 7'h00 : low_q + 7'h01;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  start_gate_a: assert property ($fell(busy_n) |-> $past(!select_n && power_down_n))
    else $error("busy fell without start");
  busy_span_a: assert property ($rose(busy_n) |-> low_q == 7'h38)
    else $error("busy low length wrong");
  sleep_hold_a: assert property (!power_down_n && busy_n |=> busy_n)
    else $error("conversion in shutdown");
  wake_quiet_a: assert property ($rose(power_down_n) |-> busy_n[*8])
    else $error("conversion during wake");
  bus_drive_a: assert property (data_oe == $past(!select_n && !read_n))
    else $error("bus enable wrong");
  result_load_a: assert property ($changed(data_out) |-> $rose(busy_n))
    else $error("result moved off busy rise");
  stall_data_a: assert property ($rose(busy_n) |-> data_oe)
    else $error("result not driven at busy rise");
  edge_only_a: assert property ($rose(busy_n) && !conversion_start_n |=> busy_n)
    else $error("level start retriggered");
  conv_c: cover property ($fell(busy_n));
  sleep_c: cover property ($fell(power_down_n));
  read_c: cover property ($rose(data_oe));
endmodule : acrc_assertions
`default_nettype wire

// ---- test/tb_adc_conversion_read_control.sv ----
// bench joining both link ends, stall-mode conversions
`timescale 1ns/10ps
`default_nettype none
module tb_adc_conversion_read_control;
  import acrc_pkg::*;
  logic       clock_i = 1'b0;
  logic       resetn_i = 1'b0;
  logic       enable_i = 1'b1;
  logic       req_i = 1'b0;
  logic       sleep_i = 1'b0;
  logic       bipolar_i = 1'b0;
  acrc_word_t sample_i = 12'h000;
  logic       shutdown_o, done_o, ready_o, valid_o;
  acrc_word_t data_o;
  int         fails = 0;
  int         n_checks = 0;
  acrc_if link ();
  always #12.5 clock_i = ~clock_i;
  acrc_dev acrc_dev_i (.clock_i(clock_i), .resetn_i(resetn_i), .enable_i(enable_i), .bus(link.dev),
    .sample_i(sample_i), .bipolar_i(bipolar_i), .shutdown_o(shutdown_o), .done_o(done_o));
  acrc_host acrc_host_i (.clock_i(clock_i), .resetn_i(resetn_i), .enable_i(enable_i), .bus(link.host),
    .req_i(req_i), .sleep_i(sleep_i), .ready_o(ready_o), .valid_o(valid_o), .data_o(data_o));
  acrc_assertions acrc_assertions_i (.clock_i(clock_i), .resetn_i(resetn_i), .select_n(link.select_n),
    .read_n(link.read_n), .conversion_start_n(link.conversion_start_n), .power_down_n(link.power_down_n),
    .busy_n(link.busy_n), .data_out(link.data_out), .data_oe(link.data_oe));
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : print_verdict
  task automatic cmp(input acrc_word_t got, input acrc_word_t exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic cmp_bit(input logic got, input logic exp);
    cmp({11'h000, got}, {11'h000, exp});
  endtask : cmp_bit
  // every wait is bounded; running out ends the run as a mismatch
  task automatic wait_hi(ref logic s);
    for (int i = 0; i < 300 && s !== 1'b1; i++)
    begin
      @(posedge clock_i);
      #2;
    end
    if (s !== 1'b1)
    begin
      fails++;
      print_verdict();
    end
  endtask : wait_hi
  task automatic convert(input acrc_word_t s, input logic b, input acrc_word_t e);
    sample_i = s;
    bipolar_i = b;
    req_i = 1'b1;
    wait_hi(ready_o);
    @(posedge clock_i);
    #2;
    req_i = 1'b0;
    wait_hi(valid_o);
    cmp(data_o, e);
  endtask : convert
  initial
  begin
    repeat (2) @(posedge clock_i);
    #2;
    resetn_i = 1'b1;
    convert(12'h000, 1'b0, 12'h000);
    convert(12'hFFF, 1'b0, 12'hFFF);
    convert(12'hA5C, 1'b0, 12'hA5C);
    convert(12'h000, 1'b1, 12'h800);
    convert(12'hFFF, 1'b1, 12'h7FF);
    sleep_i = 1'b1;
    repeat (6) @(posedge clock_i);
    #2;
    cmp_bit(shutdown_o, 1'b1);
    sleep_i = 1'b0;
    convert(12'h3C1, 1'b0, 12'h3C1);
    resetn_i = 1'b0;
    @(posedge clock_i);
    #2;
    cmp_bit(link.busy_n, 1'b1);
    cmp(link.data_out, 12'h000);
    resetn_i = 1'b1;
    convert(12'h5A5, 1'b0, 12'h5A5);
    print_verdict();
  end
endmodule : tb_adc_conversion_read_control
`default_nettype wire
